// ==== hbus_pkg.sv ====
package hbus_pkg;

    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 16;
    localparam int          IRQ_W            = 8;
    localparam int          SYNC_W           = 32;

    // Pin order in the synchroniser: cs_n, ale, rd/ds, wr/rnw, byte enable, tx last, mode, width, addr, data
    localparam logic [31:0] SYNC_RST         = 32'hf800_0000;

    localparam logic [7:0]  RX_DATA_ADDR     = 8'h00;
    localparam logic [7:0]  TX_DATA_ADDR     = 8'h01;
    localparam logic [7:0]  PORT_STATUS_ADDR = 8'h02;

    localparam logic [7:0]  ADDR_RST         = 8'h00;
    localparam logic [15:0] DATA_RST         = 16'h0000;

    localparam logic        IM_SEPARATE      = 1'b0;
    localparam logic        IM_DATA_STROBE   = 1'b1;
    localparam logic        BW_8             = 1'b0;
    localparam logic        BW_16            = 1'b1;

    localparam logic [1:0]  LANE_NONE        = 2'b00;
    localparam logic [1:0]  LANE_LOW         = 2'b01;
    localparam logic [1:0]  LANE_HIGH        = 2'b10;
    localparam logic [1:0]  LANE_BOTH        = 2'b11;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_DRIVE = 4'b0100,
        ST_WRITE = 4'b1000
    } acc_state_t;

endpackage : hbus_pkg

// ==== dl_if.sv ====
`timescale 1ns/1ps
interface dl_if;
    logic [7:0] addr;
    logic       rd_stb;
    logic       wr_stb;
    logic       last;

    modport acc (output addr, output rd_stb, output wr_stb, output last);
    modport dl  (input addr, input rd_stb, input wr_stb, input last);
endinterface : dl_if

// ==== pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
    import hbus_pkg::*;
#(
    parameter int           W       = 32,
    parameter logic [W-1:0] RST_VAL = '0
)(
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // First stage feeds only the second
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    meta_q[i] <= RST_VAL[i];
                    sync_q[i] <= RST_VAL[i];
                end else if (ce_in) begin
                    meta_q[i] <= d_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign q_out = sync_q;
endmodule : pin_sync

// ==== dl_port.sv ====
`timescale 1ns/1ps
module dl_port
    import hbus_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    dl_if.dl          bus,
    input  wire logic rx_not_empty_in,
    input  wire logic rx_msg_end_in,
    input  wire logic tx_not_full_in,
    output logic      rx_byte_request_out,
    output logic      rx_message_done_out,
    output logic      tx_byte_request_out,
    output logic      rx_pop_out,
    output logic      rx_release_out,
    output logic      tx_push_out,
    output logic      tx_push_last_out
);
    logic rx_req_q, rx_req_d, done_q, done_d, tx_req_q, tx_req_d;
    logic pop_q, pop_d, rel_q, rel_d, push_q, push_d, last_q, last_d;

    always_comb begin
        // (R18) receive request
        rx_req_d = rx_not_empty_in;
        rel_d    = bus.rd_stb && (bus.addr == PORT_STATUS_ADDR);
        pop_d    = bus.rd_stb && (bus.addr == RX_DATA_ADDR);
        // (R19) sticky until status read, set wins
        done_d   = rx_msg_end_in || (done_q && !rel_d);
        // (R20) transmit request
        tx_req_d = tx_not_full_in;
        push_d   = bus.wr_stb && (bus.addr == TX_DATA_ADDR) && tx_req_q;
        // (R21) mark final byte
        last_d   = push_d && bus.last;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rx_req_q <= 1'b0;
            done_q   <= 1'b0;
            tx_req_q <= 1'b0;
            pop_q    <= 1'b0;
            rel_q    <= 1'b0;
            push_q   <= 1'b0;
            last_q   <= 1'b0;
        end else if (ce_in) begin
            rx_req_q <= rx_req_d;
            done_q   <= done_d;
            tx_req_q <= tx_req_d;
            pop_q    <= pop_d;
            rel_q    <= rel_d;
            push_q   <= push_d;
            last_q   <= last_d;
        end
    end

    assign rx_byte_request_out = rx_req_q;
    assign rx_message_done_out = done_q;
    assign tx_byte_request_out = tx_req_q;
    assign rx_pop_out          = pop_q;
    assign rx_release_out      = rel_q;
    assign tx_push_out         = push_q;
    assign tx_push_last_out    = last_q;

    // (R19) status read clears done
    a_done_release: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in)
        (rel_d && !rx_msg_end_in) |=> !rx_message_done_out) // (R19)
        else $error("message done not released by status read");
    // (R21) last flag only with push
    a_last_with_push: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in)
        tx_push_last_out |-> tx_push_out && $past(bus.last)) // (R21)
        else $error("last flag without push");
    // (R18) request follows fifo
    a_rx_request: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in)
        rx_not_empty_in |=> rx_byte_request_out) // (R18)
        else $error("rx request missing");
    c_tx_last: cover property (@(posedge clk_in) disable iff (!nrst_in) tx_push_last_out);
endmodule : dl_port

// ==== host_port.sv ====
// Function
// (R1) Bus width input low gives 8-bit data bus, high gives 16-bit.
// (R2) In 8-bit mode only low byte driven; upper lines float, board ties them.
// (R3) In 16-bit byte transfers lane follows address bit zero, byte enable, mode.
// (R4) Eight address bits pick exactly one register per access.
// (R5) Strobes act only while chip select is low.
// (R6) Address captured when latch strobe falls, held for the access.
// (R7) Multiplexed bus: board wires address pins to data lines.
// (R8) Demultiplexed bus: board holds latch strobe high, latch transparent.
// (R9) Separate-strobe mode: low read strobe reads and drives the bus.
// (R10) Separate-strobe mode: low write strobe writes host data.
// (R11) Data-strobe mode: drive read data while strobe low; write data valid.
// (R12) Data-strobe mode: read-not-write level chooses read or write.
// (R13) Pending interrupt pulls open-drain interrupt line low.
// (R14) Each interrupt source maskable; masked sources never drive the line.
// (R15) Separate strobes, 16-bit: upper byte enable means upper lane transfer.
// (R16) Data strobe, 16-bit: byte access input means lower lane transfer.
// (R17) In 8-bit mode the byte enable input is ignored.
// (R18) Receive byte request high while receive fifo holds a byte.
// (R19) Receive done raised at message end; status read releases fifo.
// (R20) Transmit byte request high while transmit fifo has room.
// (R21) Message end with a requested write marks the final byte.
// (R22) Controller drives message end in the same write as last byte.
// (R23) Static mode input picks separate-strobe (low) or data-strobe (high).
// (R24) Reset clears state, drops fifo requests, releases interrupt line.
`timescale 1ns/1ps
module host_port
    import hbus_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              ce_in,
    input  wire logic              interface_mode_select_in,
    input  wire logic              bus_width_select_in,
    input  wire logic [ADDR_W-1:0] host_address_in,
    input  wire logic [DATA_W-1:0] host_data_in,
    output logic      [DATA_W-1:0] host_data_out,
    output logic      [1:0]        host_data_oe_n_out,
    input  wire logic              chip_select_n_in,
    input  wire logic              address_latch_strobe_in,
    input  wire logic              read_strobe_n_in,
    input  wire logic              write_strobe_n_in,
    input  wire logic              byte_enable_n_in,
    output logic                   interrupt_request_n_out,
    output logic                   interrupt_request_oe_n_out,
    input  wire logic [IRQ_W-1:0]  irq_pending_in,
    input  wire logic [IRQ_W-1:0]  irq_mask_in,
    output logic      [ADDR_W-1:0] reg_addr_out,
    output logic      [DATA_W-1:0] reg_wdata_out,
    output logic      [1:0]        reg_be_out,
    output logic                   reg_wr_out,
    output logic                   reg_rd_out,
    input  wire logic [DATA_W-1:0] reg_rdata_in,
    input  wire logic              rx_not_empty_in,
    input  wire logic              rx_msg_end_in,
    input  wire logic              tx_not_full_in,
    input  wire logic              tx_message_last_in,
    output logic                   rx_byte_request_out,
    output logic                   rx_message_done_out,
    output logic                   tx_byte_request_out,
    output logic                   rx_pop_out,
    output logic                   rx_release_out,
    output logic                   tx_push_out,
    output logic                   tx_push_last_out
);
    logic [SYNC_W-1:0] sync_s;
    logic              cs_n_s, ale_s, rd_n_s, wr_n_s, be_n_s, tx_message_last_s, im_s, bw_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;

    pin_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .ce_in   (ce_in),
        .d_in    ({chip_select_n_in, address_latch_strobe_in, read_strobe_n_in, write_strobe_n_in,
                   byte_enable_n_in, tx_message_last_in, interface_mode_select_in, bus_width_select_in,
                   host_address_in, host_data_in}),
        .q_out   (sync_s)
    );

    assign {cs_n_s, ale_s, rd_n_s, wr_n_s, be_n_s, tx_message_last_s, im_s, bw_s, addr_s, data_s} = sync_s;

    acc_state_t        state_q, state_d;
    logic [ADDR_W-1:0] alat_q, alat_d, raddr_q, raddr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d, wbuf_q, wbuf_d;
    logic [1:0]        be_q, be_d, lane_q, lane_d, oe_n_q, oe_n_d;
    logic              wr_q, wr_d, rd_q, rd_d, last_q, last_d, lastbuf_q, lastbuf_d, irq_oe_n_q, irq_oe_n_d;
    logic              sel, rd_act, wr_act;
    logic [1:0]        lane_c, be_c;

    // (R5) chip select gates strobes
    assign sel = !cs_n_s;

    // (R9) (R10) (R11) (R12) (R23) strobe decode per mode
    always_comb begin
        if (im_s == IM_DATA_STROBE) begin
            rd_act = sel && !rd_n_s && wr_n_s;
            wr_act = sel && !rd_n_s && !wr_n_s;
        end else begin
            rd_act = sel && !rd_n_s;
            wr_act = sel && !wr_n_s;
        end
    end

    // (R1) (R3) (R15) (R16) (R17) lane and byte selection
    // Latch output, not its register, so an address set with the strobe is not a cycle late
    always_comb begin
        if (bw_s == BW_8) begin
            lane_c = LANE_LOW;
            be_c   = alat_d[0] ? LANE_HIGH : LANE_LOW;
        end else if (im_s == IM_SEPARATE) begin
            case ({alat_d[0], be_n_s})
                2'b00:   lane_c = LANE_BOTH;
                2'b01:   lane_c = LANE_LOW;
                2'b10:   lane_c = LANE_HIGH;
                default: lane_c = LANE_NONE;
            endcase
            be_c = lane_c;
        end else begin
            lane_c = be_n_s ? LANE_BOTH : LANE_LOW;
            be_c   = lane_c;
        end
    end

    always_comb begin
        state_d   = state_q;
        // (R6) (R8) latch transparent while strobe high, holds after fall
        alat_d    = ale_s ? addr_s : alat_q;
        raddr_d   = raddr_q;
        wdata_d   = wdata_q;
        wbuf_d    = wbuf_q;
        rdata_d   = rdata_q;
        be_d      = be_q;
        lane_d    = lane_q;
        oe_n_d    = LANE_BOTH;
        wr_d      = 1'b0;
        rd_d      = 1'b0;
        last_d    = last_q;
        lastbuf_d = lastbuf_q;
        case (state_q)
            ST_IDLE: begin
                if (rd_act) begin
                    // (R4) one register per access
                    raddr_d = alat_d;
                    be_d    = be_c;
                    lane_d  = lane_c;
                    rd_d    = 1'b1;
                    state_d = ST_READ;
                end else if (wr_act) begin
                    raddr_d = alat_d;
                    be_d    = be_c;
                    lane_d  = lane_c;
                    state_d = ST_WRITE;
                end
            end
            ST_READ: begin
                if (bw_s == BW_8)
                    rdata_d = {8'h00, (be_q == LANE_HIGH) ? reg_rdata_in[15:8] : reg_rdata_in[7:0]};
                else
                    rdata_d = reg_rdata_in;
                state_d = rd_act ? ST_DRIVE : ST_IDLE;
                oe_n_d  = rd_act ? ~lane_q : LANE_BOTH;
            end
            ST_DRIVE: begin
                // (R2) (R9) (R11) drive active lanes only
                oe_n_d  = rd_act ? ~lane_q : LANE_BOTH;
                state_d = rd_act ? ST_DRIVE : ST_IDLE;
            end
            ST_WRITE: begin
                // Data sampled up to strobe release, valid at its end in both modes
                if (wr_act) begin
                    wbuf_d    = (bw_s == BW_8) ? {data_s[7:0], data_s[7:0]} : data_s;
                    lastbuf_d = tx_message_last_s;
                end else begin
                    // (R10) (R11) commit write on release
                    wdata_d = wbuf_q;
                    last_d  = lastbuf_q;
                    wr_d    = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (bw_s == BW_8)
            oe_n_d[1] = 1'b1;
        // (R13) (R14) unmasked sources pull line low
        irq_oe_n_d = !(|(irq_pending_in & ~irq_mask_in));
    end

    // (R24) reset to idle defaults
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q    <= ST_IDLE;
            alat_q     <= ADDR_RST;
            raddr_q    <= ADDR_RST;
            wdata_q    <= DATA_RST;
            wbuf_q     <= DATA_RST;
            rdata_q    <= DATA_RST;
            be_q       <= LANE_NONE;
            lane_q     <= LANE_NONE;
            oe_n_q     <= LANE_BOTH;
            wr_q       <= 1'b0;
            rd_q       <= 1'b0;
            last_q     <= 1'b0;
            lastbuf_q  <= 1'b0;
            irq_oe_n_q <= 1'b1;
        end else if (ce_in) begin
            state_q    <= state_d;
            alat_q     <= alat_d;
            raddr_q    <= raddr_d;
            wdata_q    <= wdata_d;
            wbuf_q     <= wbuf_d;
            rdata_q    <= rdata_d;
            be_q       <= be_d;
            lane_q     <= lane_d;
            oe_n_q     <= oe_n_d;
            wr_q       <= wr_d;
            rd_q       <= rd_d;
            last_q     <= last_d;
            lastbuf_q  <= lastbuf_d;
            irq_oe_n_q <= irq_oe_n_d;
        end
    end

    assign host_data_out              = rdata_q;
    assign host_data_oe_n_out         = oe_n_q;
    assign interrupt_request_n_out    = 1'b0;
    assign interrupt_request_oe_n_out = irq_oe_n_q;
    assign reg_addr_out               = raddr_q;
    assign reg_wdata_out              = wdata_q;
    assign reg_be_out                 = be_q;
    assign reg_wr_out                 = wr_q;
    assign reg_rd_out                 = rd_q;

    dl_if dl_bus ();
    assign dl_bus.addr   = raddr_q;
    assign dl_bus.rd_stb = rd_q;
    assign dl_bus.wr_stb = wr_q;
    // (R22) end flag taken with the byte
    assign dl_bus.last   = last_q;

    dl_port u_dl (
        .clk_in              (clk_in),
        .nrst_in             (nrst_in),
        .ce_in               (ce_in),
        .bus                 (dl_bus.dl),
        .rx_not_empty_in     (rx_not_empty_in),
        .rx_msg_end_in       (rx_msg_end_in),
        .tx_not_full_in      (tx_not_full_in),
        .rx_byte_request_out (rx_byte_request_out),
        .rx_message_done_out (rx_message_done_out),
        .tx_byte_request_out (tx_byte_request_out),
        .rx_pop_out          (rx_pop_out),
        .rx_release_out      (rx_release_out),
        .tx_push_out         (tx_push_out),
        .tx_push_last_out    (tx_push_last_out)
    );

    // (R2) upper lane floats in 8-bit mode
    a_upper_lane_float: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R2)
        (bw_s == BW_8) ##1 (bw_s == BW_8) |-> host_data_oe_n_out[1])
        else $error("upper lane driven in 8-bit mode");
    // (R5) no access without select
    a_select_gates: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R5)
        (state_q == ST_IDLE && cs_n_s) |=> !reg_rd_out && !reg_wr_out)
        else $error("access without chip select");
    // (R9) read strobe starts read
    a_read_start: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R9)
        (state_q == ST_IDLE && rd_act) |=> reg_rd_out ##1 (state_q != ST_READ))
        else $error("read not issued");
    // (R11) drive active lanes while reading
    a_drive_lanes: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R11)
        (state_q == ST_DRIVE) |-> (host_data_oe_n_out == (~lane_q | {bw_s == BW_8, 1'b0})))
        else $error("wrong lanes driven");
    // (R10) release commits write
    a_write_commit: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R10)
        (state_q == ST_WRITE && !wr_act) |=> reg_wr_out && reg_wdata_out == $past(wbuf_q))
        else $error("write not committed");
    // (R12) level picks write
    a_rnw_write: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R12)
        (state_q == ST_IDLE && im_s == IM_DATA_STROBE && sel && !rd_n_s && !wr_n_s) |=> state_q == ST_WRITE)
        else $error("read-not-write low did not write");
    // (R6) latch holds while strobe low
    a_latch_hold: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R6)
        !ale_s |=> $stable(alat_q))
        else $error("address latch moved while closed");
    // (R15) upper byte enable
    a_upper_enable: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R15)
        (state_q == ST_IDLE && rd_act && bw_s == BW_16 && im_s == IM_SEPARATE && alat_d[0] && !be_n_s)
        |=> reg_be_out == LANE_HIGH)
        else $error("upper byte not selected");
    // (R16) byte access lower lane
    a_lower_access: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R16)
        (state_q == ST_IDLE && (rd_act || wr_act) && bw_s == BW_16 && im_s == IM_DATA_STROBE && !be_n_s)
        |=> reg_be_out == LANE_LOW)
        else $error("lower byte not selected");
    // (R17) enable ignored in 8-bit mode
    a_eight_bit_be: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R17)
        (state_q == ST_IDLE && rd_act && bw_s == BW_8) |=> reg_be_out == ($past(alat_d[0]) ? LANE_HIGH : LANE_LOW))
        else $error("byte enable used in 8-bit mode");
    // (R14) masked sources stay quiet
    a_irq_masked: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R14)
        !(|(irq_pending_in & ~irq_mask_in)) |=> interrupt_request_oe_n_out)
        else $error("masked source drove interrupt");
    // (R13) pending source pulls low
    a_irq_pull: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // (R13)
        (|(irq_pending_in & ~irq_mask_in)) |=> !interrupt_request_oe_n_out && !interrupt_request_n_out)
        else $error("interrupt not pulled low");
    // (R24) reset releases outputs
    a_reset_idle: assert property (@(posedge clk_in) // (R24)
        !nrst_in |=> host_data_oe_n_out == LANE_BOTH && interrupt_request_oe_n_out && !rx_byte_request_out
        && !tx_byte_request_out)
        else $error("reset left outputs active");

    c_read_done:  cover property (@(posedge clk_in) disable iff (!nrst_in) state_q == ST_DRIVE ##1 state_q == ST_IDLE);
    c_write_done: cover property (@(posedge clk_in) disable iff (!nrst_in) reg_wr_out && im_s == IM_DATA_STROBE);
    c_irq_low:    cover property (@(posedge clk_in) disable iff (!nrst_in) !interrupt_request_oe_n_out);
endmodule : host_port

// ==== reg_file_model.sv ====
`timescale 1ns/1ps
module reg_file_model
    import hbus_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic [1:0]        reg_be_in,
    input  wire logic              reg_wr_in,
    output logic      [DATA_W-1:0] reg_rdata_out
);
    logic [DATA_W-1:0] mem_q [0:255];
    initial foreach (mem_q[i]) mem_q[i] = '0;
    always @(posedge clk_in) begin
        if (reg_wr_in && reg_be_in[0]) mem_q[reg_addr_in][7:0] <= reg_wdata_in[7:0];
        if (reg_wr_in && reg_be_in[1]) mem_q[reg_addr_in][15:8] <= reg_wdata_in[15:8];
    end
    assign reg_rdata_out = mem_q[reg_addr_in];
endmodule : reg_file_model

// ==== host_bus_and_datalink_dma_port_tb_top.sv ====
`timescale 1ns/1ps
module host_bus_and_datalink_dma_port_tb_top
    import hbus_pkg::*;
;
    logic clk_in = 0, nrst_p = 0, mode_p = 0, bw_p = 1, cs_p = 1, rd_p = 1, wr_p = 1, be_p = 1;
    logic tl_p = 0, rx_ne = 0, rx_end = 0, tx_nf = 0, oe_irq, irq_n, rx_req, rx_done, tx_req;
    logic rd_pl, wr_pl, pop, rel, push, push_last, ale_p = 1, mux_p = 0;
    logic [7:0]  addr_p = '0, ra, wa, pend = '0, mask = '0;
    logic [15:0] data_p = '0, dout, wd, wdata, rdata, obs_d;
    logic [1:0]  oe, wb, be, obs_oe;
    int err_total = 0, samples_checked = 0, wr_cnt = 0, rel_cnt = 0, last_cnt = 0, pop_cnt = 0, rd_cnt = 0, cyc = 0;
    always #20 clk_in = ~clk_in;
    host_port dut_u (.clk_in(clk_in), .nrst_in(nrst_p), .ce_in(1'b1), .interface_mode_select_in(mode_p),
        .bus_width_select_in(bw_p), .host_address_in(mux_p ? data_p[7:0] : addr_p), .host_data_in(data_p),
        .host_data_out(dout), .host_data_oe_n_out(oe), .chip_select_n_in(cs_p), .address_latch_strobe_in(ale_p),
        .read_strobe_n_in(rd_p), .write_strobe_n_in(wr_p), .byte_enable_n_in(be_p),
        .interrupt_request_n_out(irq_n), .interrupt_request_oe_n_out(oe_irq), .irq_pending_in(pend),
        .irq_mask_in(mask), .reg_addr_out(ra), .reg_wdata_out(wdata), .reg_be_out(be), .reg_wr_out(wr_pl),
        .reg_rd_out(rd_pl), .reg_rdata_in(rdata), .rx_not_empty_in(rx_ne), .rx_msg_end_in(rx_end),
        .tx_not_full_in(tx_nf), .tx_message_last_in(tl_p), .rx_byte_request_out(rx_req),
        .rx_message_done_out(rx_done), .tx_byte_request_out(tx_req), .rx_pop_out(pop),
        .rx_release_out(rel), .tx_push_out(push), .tx_push_last_out(push_last));
    reg_file_model rf_u (.clk_in(clk_in), .reg_addr_in(ra), .reg_wdata_in(wdata), .reg_be_in(be),
        .reg_wr_in(wr_pl), .reg_rdata_out(rdata));
    always @(posedge clk_in) begin
        cyc++;
        if (wr_pl === 1'b1) begin
            wr_cnt++;
            wd = wdata;
            wb = be;
            wa = ra;
        end
        if (rd_pl === 1'b1) rd_cnt++;
        if (pop === 1'b1) pop_cnt++;
        if (rel === 1'b1) rel_cnt++;
        if (push_last === 1'b1) last_cnt++;
        // Hang guard, far above the few hundred cycles needed
        if (cyc == 4000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Strobe held 8 cycles to cover the synchroniser and drive latency
    task automatic acc(input logic rd, input logic [7:0] a, input logic [15:0] d, input logic bn, input logic cn);
        @(posedge clk_in);
        #2;
        addr_p = a;
        data_p = d;
        be_p = bn;
        cs_p = cn;
        // level picks direction in data-strobe mode
        rd_p = mode_p ? 1'b0 : ~rd;
        wr_p = rd;
        repeat (7) @(posedge clk_in);
        #2;
        obs_oe = oe;
        obs_d = dout;
        @(posedge clk_in);
        #2;
        rd_p = 1;
        wr_p = 1;
        cs_p = 1;
        tl_p = 0;
        repeat (6) @(posedge clk_in);
    endtask : acc
    task automatic s_sep16();
        acc(0, 8'h10, 16'ha55a, 1'b0, 1'b0);
        chk({wb, wd[13:0]}, {2'b11, 14'h255a});
        chk({8'h0, wa}, 16'h0010);
        acc(1, 8'h10, 16'h0000, 1'b0, 1'b0);
        chk({obs_oe, obs_d[13:0]}, {2'b00, 14'h255a});
        chk({14'h0, obs_d[15:14]}, 16'h0002);
        chk(16'(rd_cnt), 16'h0001);
        acc(1, 8'h10, 16'h0000, 1'b1, 1'b0);
        chk({14'h0, obs_oe}, 16'h0002);
        acc(1, 8'h11, 16'h0000, 1'b0, 1'b0);
        chk({14'h0, obs_oe}, 16'h0001);
    endtask : s_sep16
    task automatic s_mux();
        // board wires the address pins to the data lines
        #2 mux_p = 1;
        data_p = 16'h0044;
        repeat (3) @(posedge clk_in);
        #2 ale_p = 0;
        acc(0, 8'h00, 16'h5aa5, 1'b0, 1'b0);
        chk({wa, wd[7:0]}, 16'h44a5);
        #2 mux_p = 0;
        ale_p = 1;
        acc(1, 8'h44, 16'h0000, 1'b0, 1'b0);
        chk(obs_d, 16'h5aa5);
    endtask : s_mux
    task automatic s_ds16();
        #2 mode_p = IM_DATA_STROBE;
        acc(0, 8'h20, 16'h1234, 1'b1, 1'b0);
        chk(wd, 16'h1234);
        acc(1, 8'h20, 16'h0000, 1'b1, 1'b0);
        chk(obs_d, 16'h1234);
        acc(1, 8'h20, 16'h0000, 1'b0, 1'b0);
        chk({14'h0, obs_oe}, 16'h0002);
        #2 mode_p = IM_SEPARATE;
        @(posedge clk_in);
    endtask : s_ds16
    task automatic s_bus8();
        int n;
        #2 bw_p = BW_8;
        acc(0, 8'h30, 16'h003c, 1'b0, 1'b0);
        chk({wb, wd[13:0]}, {2'b01, 14'h3c3c});
        acc(1, 8'h31, 16'h0000, 1'b0, 1'b0);
        chk({14'h0, obs_oe}, 16'h0002);
        n = wr_cnt;
        acc(0, 8'h30, 16'h00ff, 1'b1, 1'b1);
        chk(16'(wr_cnt - n), 16'h0000);
        chk({14'h0, obs_oe}, 16'h0003);
        #2 bw_p = BW_16;
        @(posedge clk_in);
    endtask : s_bus8
    task automatic s_irq();
        #2 pend = 8'h04;
        repeat (3) @(posedge clk_in);
        chk({14'h0, oe_irq, irq_n}, 16'h0000);
        #2 mask = 8'h04;
        repeat (3) @(posedge clk_in);
        chk({15'h0, oe_irq}, 16'h0001);
    endtask : s_irq
    task automatic s_link();
        #2 rx_ne = 1;
        tx_nf = 1;
        rx_end = 1;
        @(posedge clk_in);
        #2 rx_end = 0;
        repeat (3) @(posedge clk_in);
        chk({13'h0, rx_req, rx_done, tx_req}, 16'h0007);
        acc(1, PORT_STATUS_ADDR, 16'h0000, 1'b0, 1'b0);
        chk({14'h0, rx_done, 1'(rel_cnt)}, 16'h0001);
        acc(1, RX_DATA_ADDR, 16'h0000, 1'b0, 1'b0);
        chk(16'(pop_cnt), 16'h0001);
        // message end driven with the final byte
        #2 tl_p = 1;
        acc(0, TX_DATA_ADDR, 16'h007e, 1'b0, 1'b0);
        chk(16'(last_cnt), 16'h0001);
        // Mid-run reset with both requests and an unmasked source active
        #2 mask = 8'h00;
        nrst_p = 0;
        repeat (2) @(posedge clk_in);
        #2 chk({12'h0, oe_irq, rx_req, rx_done, tx_req}, 16'h0008);
        nrst_p = 1;
        repeat (3) @(posedge clk_in);
    endtask : s_link
    task automatic print_verdict();
        $display("checked=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge clk_in);
        #2 chk({11'h0, oe, oe_irq, rx_req, tx_req}, 16'h001c);
        nrst_p = 1;
        repeat (3) @(posedge clk_in);
        s_sep16();
        s_mux();
        s_ds16();
        s_bus8();
        s_irq();
        s_link();
        print_verdict();
    end
endmodule : host_bus_and_datalink_dma_port_tb_top
